// ### vab_addr_decode.sv
// maps an apb byte address onto a register slot of the bank
// assumes word-aligned addresses; low two bits must be zero for a hit
`timescale 1ns/100ps
`include "vab_consts.svh"

module vab_addr_decode (
  // bus side
  input  wire logic [7:0]         paddr_i,
  // slot side
  output vab_pkg::vab_slot_t      slot_o,
  output logic                    hit_o
);

  logic [5:0] idx;

  ////////////////////////////////////////////////////////////////////////////
  // index lookup, misaligned addresses never hit
  always_comb
  begin
    idx    = paddr_i[7:2];
    slot_o = 4'h0;
    hit_o  = (paddr_i[1:0] == 2'b00);
    case (idx)
      `VAB_IDX_CROP_HIGH:   slot_o = 4'h0;
      `VAB_IDX_PIXEL_LOW:   slot_o = 4'h1;
      `VAB_IDX_CONTROL_ONE: slot_o = 4'h2;
      `VAB_IDX_VRATIO_LOW:  slot_o = 4'h3;
      `VAB_IDX_SCALE_HIGH:  slot_o = 4'h4;
      `VAB_IDX_HRATIO_LOW:  slot_o = 4'h5;
      `VAB_IDX_BRIGHTNESS:  slot_o = 4'h6;
      `VAB_IDX_CONTRAST:    slot_o = 4'h7;
      `VAB_IDX_SHARPEN:     slot_o = 4'h8;
      default:              hit_o  = 1'b0;
    endcase
  end

endmodule // vab_addr_decode

// ### vab_consts.svh
// offsets, field positions, reset values and widths of the video adjust bank
// assumes the includer reads registers by word index, byte address = 4 * index
`ifndef VAB_CONSTS_SVH
`define VAB_CONSTS_SVH

// register index (byte address is four times this)
`define VAB_IDX_CROP_HIGH     6'h07
`define VAB_IDX_PIXEL_LOW     6'h0b
`define VAB_IDX_CONTROL_ONE   6'h0c
`define VAB_IDX_VRATIO_LOW    6'h0d
`define VAB_IDX_SCALE_HIGH    6'h0e
`define VAB_IDX_HRATIO_LOW    6'h0f
`define VAB_IDX_BRIGHTNESS    6'h10
`define VAB_IDX_CONTRAST      6'h11
`define VAB_IDX_SHARPEN       6'h12

// reset values
`define VAB_RST_CROP_HIGH     8'h02
`define VAB_RST_PIXEL_LOW     8'hd0
`define VAB_RST_CONTROL_ONE   8'h8c
`define VAB_RST_VRATIO_LOW    8'h00
`define VAB_RST_SCALE_HIGH    8'h11
`define VAB_RST_HRATIO_LOW    8'h00
`define VAB_RST_BRIGHTNESS    8'h00
`define VAB_RST_CONTRAST      8'h60
`define VAB_RST_SHARPEN       8'h01

// control one bit positions
`define VAB_BIT_WIDE_BAND     7
`define VAB_BIT_PHASE_SENS    5
`define VAB_BIT_PEDESTAL      4
`define VAB_BIT_COMB          3
`define VAB_BIT_LUMA_AVG      1
`define VAB_BIT_CHROMA_AVG    0

// sharpening control fields
`define VAB_BIT_SHARPEN_LEVEL_CENTRE  7
`define VAB_SHARPEN_LEVEL_NOISE_MIN   4'h8

// luma path
`define VAB_CONTRAST_UNITY    8'h40
`define VAB_CONTRAST_SHIFT    6
`define VAB_PEDESTAL_CODE     8'h10
`define VAB_LUMA_MAX          11'sh0ff

`endif

// ### vab_luma_adjust.sv
// contrast gain, brightness offset and pedestal on an 8-bit luma stream
// assumes settings change only between lines; one cycle of latency
`timescale 1ns/100ps
`include "vab_consts.svh"

module vab_luma_adjust (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // settings
  input  wire logic [7:0]  contrast_i,
  input  wire logic [7:0]  brightness_i,
  input  wire logic        pedestal_i,
  // stream
  input  wire logic [7:0]  luma_i,
  input  wire logic        luma_valid_i,
  output logic [7:0]       luma_o,
  output logic             luma_valid_o
);

  logic [15:0]        product;
  logic signed [11:0] sum;
  logic [7:0]         luma_d;
  logic [7:0]         luma_q;
  logic               valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // gain is code/64, so 40h is unity and ffh about 3.98
  always_comb
  begin
    product = luma_i * contrast_i;
    sum     = $signed({2'b00, product[15:`VAB_CONTRAST_SHIFT]}) + 12'($signed(brightness_i));
    if (pedestal_i)
      sum = sum + $signed({4'h0, `VAB_PEDESTAL_CODE});
    // clamp instead of wrapping, a wrap would flash white to black
    if (sum < 12'sh000)
      luma_d = 8'h00;
    else if (sum > 12'($signed(`VAB_LUMA_MAX)))
      luma_d = 8'hff;
    else
      luma_d = sum[7:0];
  end

  // output sample register
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      luma_q <= 8'h00;
    else if (luma_valid_i)
      luma_q <= luma_d;
  end

  // valid follows luma_valid_i by one cycle, in step with the data register
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      valid_q <= 1'b0;
    else
      valid_q <= luma_valid_i;
  end

  assign luma_o       = luma_q;
  assign luma_valid_o = valid_q;

endmodule // vab_luma_adjust

// ### vab_pkg.sv
// types shared by the video adjust bank
// assumes nothing beyond a SystemVerilog compiler
package vab_pkg;

  // what the sharpness level field asks of the luma filter
  typedef enum logic [1:0] {
    VAB_SHARPEN_LEVEL_OFF     = 2'b00,
    VAB_SHARPEN_LEVEL_ENHANCE = 2'b01,
    VAB_SHARPEN_LEVEL_DENOISE = 2'b10
  } vab_sharpen_level_mode_t;

  // register slot inside the bank
  typedef logic [3:0] vab_slot_t;

endpackage

// ### vab_register_bank.sv
// apb register bank of the video decoder adjust controls, with luma adjust
// assumes a 40 MHz sys_clk_i and an apb master on the same clock
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "vab_consts.svh"

module vab_register_bank #(
  parameter int SLOTS = 9
) (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  resetn_i,
  // apb slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic [31:0]                prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // line format and separation
  output logic [9:0]                 active_pixel_count_o,
  output logic                       wide_chroma_band_o,
  output logic                       phase_switch_sensitivity_o,
  output logic                       pedestal_select_o,
  output logic                       comb_adaptive_o,
  output logic                       luma_line_average_o,
  output logic                       chroma_line_average_o,
  // down scaler
  output logic [11:0]                vertical_ratio_o,
  output logic [11:0]                horizontal_ratio_o,
  // luma enhancement
  output logic [7:0]                 brightness_offset_o,
  output logic [7:0]                 contrast_gain_o,
  output logic                       sharpen_centre_select_o,
  output logic [3:0]                 sharpen_level_o,
  output vab_pkg::vab_sharpen_level_mode_t   sharpen_mode_o,
  // luma stream
  input  wire logic [7:0]            luma_i,
  input  wire logic                  luma_valid_i,
  output logic [7:0]                 luma_o,
  output logic                       luma_valid_o
);

  // reset image of every slot, same order as the address decoder
  localparam logic [7:0] RST_VAL [SLOTS] = '{
    `VAB_RST_CROP_HIGH,  `VAB_RST_PIXEL_LOW, `VAB_RST_CONTROL_ONE,
    `VAB_RST_VRATIO_LOW, `VAB_RST_SCALE_HIGH, `VAB_RST_HRATIO_LOW,
    `VAB_RST_BRIGHTNESS, `VAB_RST_CONTRAST,  `VAB_RST_SHARPEN
  };

  logic [7:0]          regs_q [SLOTS];
  vab_pkg::vab_slot_t  slot;
  logic                hit;
  logic                setup;
  logic                access;
  logic                wr_en;
  logic [31:0]         prdata_q;
  logic [7:0]          ctrl;
  logic [7:0]          sharpen_level;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  vab_addr_decode u_decode (
    .paddr_i (paddr_i),
    .slot_o  (slot),
    .hit_o   (hit)
  );

  // apb phases; writes land only on the access edge
  assign setup  = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign wr_en  = access && pwrite_i && hit;

  ////////////////////////////////////////////////////////////////////////////
  // one byte register per slot, reserved bits kept as written
  for (genvar g = 0; g < SLOTS; g++)
  begin : g_slot
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
        regs_q[g] <= RST_VAL[g];
      else if (wr_en && (slot == 4'(g)))
        regs_q[g] <= pwdata_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data captured in setup so the access phase needs no wait
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prdata_q <= 32'h0000_0000;
    else if (setup && !pwrite_i)
      prdata_q <= hit ? {24'h00_0000, regs_q[slot]} : 32'h0000_0000;
  end

  // zero wait state; unmapped or misaligned access answers with an error
  assign prdata_o  = prdata_q;
  assign pready_o  = 1'b1;
  assign pslverr_o = access && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // line format and separation controls
  assign ctrl = regs_q[2];
  assign active_pixel_count_o       = {regs_q[0][1:0], regs_q[1]};
  assign wide_chroma_band_o         = ctrl[`VAB_BIT_WIDE_BAND];
  assign phase_switch_sensitivity_o = ctrl[`VAB_BIT_PHASE_SENS];
  assign pedestal_select_o          = ctrl[`VAB_BIT_PEDESTAL];
  assign comb_adaptive_o            = ctrl[`VAB_BIT_COMB];
  assign luma_line_average_o        = ctrl[`VAB_BIT_LUMA_AVG];
  assign chroma_line_average_o      = ctrl[`VAB_BIT_CHROMA_AVG];

  // scaler ratios share one high register
  assign vertical_ratio_o   = {regs_q[4][7:4], regs_q[3]};
  assign horizontal_ratio_o = {regs_q[4][3:0], regs_q[5]};

  // enhancement settings
  assign sharpen_level                   = regs_q[8];
  assign brightness_offset_o     = regs_q[6];
  assign contrast_gain_o         = regs_q[7];
  assign sharpen_centre_select_o = sharpen_level[`VAB_BIT_SHARPEN_LEVEL_CENTRE];
  assign sharpen_level_o         = sharpen_level[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // sharpen level to filter mode
  always_comb
  begin
    if (sharpen_level[3:0] == 4'h0)
      sharpen_mode_o = vab_pkg::VAB_SHARPEN_LEVEL_OFF;
    else if (sharpen_level[3:0] < `VAB_SHARPEN_LEVEL_NOISE_MIN)
      sharpen_mode_o = vab_pkg::VAB_SHARPEN_LEVEL_ENHANCE;
    else
      sharpen_mode_o = vab_pkg::VAB_SHARPEN_LEVEL_DENOISE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // luma path: gain, offset, pedestal
  vab_luma_adjust u_luma (
    .sys_clk_i    (sys_clk_i),
    .resetn_i     (resetn_i),
    .contrast_i   (regs_q[7]),
    .brightness_i (regs_q[6]),
    .pedestal_i   (ctrl[`VAB_BIT_PEDESTAL]),
    .luma_i       (luma_i),
    .luma_valid_i (luma_valid_i),
    .luma_o       (luma_o),
    .luma_valid_o (luma_valid_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks on the bank
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // a completed write to one register index
  sequence s_write(logic [5:0] idx);
    psel_i && penable_i && pwrite_i && (paddr_i == {idx, 2'b00});
  endsequence

  // a read setup followed by its access
  sequence s_read(logic [5:0] idx);
    psel_i && !penable_i && !pwrite_i && (paddr_i == {idx, 2'b00}) ##1
    psel_i && penable_i;
  endsequence

  // a luma sample taken with unity gain and no offset
  sequence s_plain_sample;
    luma_valid_i && contrast_gain_o == `VAB_CONTRAST_UNITY && brightness_offset_o == 8'h00;
  endsequence

  AST_PIXEL_LOW: assert property (s_write(`VAB_IDX_PIXEL_LOW) |=>
    active_pixel_count_o[7:0] == $past(pwdata_i[7:0]))
    else $error("pixel count low byte not written");

  AST_PIXEL_HIGH: assert property (s_write(`VAB_IDX_CROP_HIGH) |=>
    active_pixel_count_o[9:8] == $past(pwdata_i[1:0]))
    else $error("pixel count top bits not written");

  AST_RESET_IMAGE: assert property ($rose(resetn_i) |->
    active_pixel_count_o == 10'h2d0 && wide_chroma_band_o && comb_adaptive_o &&
    !phase_switch_sensitivity_o && !pedestal_select_o && contrast_gain_o == 8'h60)
    else $error("wrong reset image");

  AST_CONTROL_BITS: assert property (s_write(`VAB_IDX_CONTROL_ONE) |=>
    {wide_chroma_band_o, phase_switch_sensitivity_o, pedestal_select_o, comb_adaptive_o,
     luma_line_average_o, chroma_line_average_o} ==
    {$past(pwdata_i[7]), $past(pwdata_i[5]), $past(pwdata_i[4]), $past(pwdata_i[3]),
     $past(pwdata_i[1]), $past(pwdata_i[0])})
    else $error("control one bits wrong after write");

  AST_VRATIO_HIGH: assert property (s_write(`VAB_IDX_SCALE_HIGH) |=>
    vertical_ratio_o[11:8] == $past(pwdata_i[7:4]))
    else $error("vertical ratio high nibble wrong");

  AST_HRATIO_HIGH: assert property (s_write(`VAB_IDX_SCALE_HIGH) |=>
    horizontal_ratio_o[11:8] == $past(pwdata_i[3:0]))
    else $error("horizontal ratio high nibble wrong");

  AST_LUMA_NEUTRAL: assert property (luma_valid_i && brightness_offset_o == 8'h00 &&
    contrast_gain_o == `VAB_CONTRAST_UNITY && !pedestal_select_o |=>
    luma_valid_o && luma_o == $past(luma_i))
    else $error("neutral settings altered luma");

  AST_BRIGHTNESS_OFFSET_RAISE: assert property (luma_valid_i && contrast_gain_o == `VAB_CONTRAST_UNITY &&
    !pedestal_select_o && !brightness_offset_o[7] && luma_i < 8'h40 |=>
    luma_o == $past(luma_i) + $past(brightness_offset_o) || luma_o == 8'hff)
    else $error("positive brightness did not raise luma");

  AST_SHARPEN_LEVEL_CENTRE: assert property (s_write(`VAB_IDX_SHARPEN) |=>
    sharpen_centre_select_o == $past(pwdata_i[7]))
    else $error("sharpen centre not written");

  AST_SHARPEN_LEVEL_MODE: assert property ((sharpen_level_o == 4'h0) ==
    (sharpen_mode_o == vab_pkg::VAB_SHARPEN_LEVEL_OFF) &&
    (sharpen_level_o >= 4'h8) == (sharpen_mode_o == vab_pkg::VAB_SHARPEN_LEVEL_DENOISE))
    else $error("sharpen mode does not match level");

  AST_READBACK: assert property (s_read(`VAB_IDX_CONTROL_ONE) |->
    prdata_o == {24'h00_0000, wide_chroma_band_o, $past(ctrl[6]), phase_switch_sensitivity_o,
    pedestal_select_o, comb_adaptive_o, $past(ctrl[2]), luma_line_average_o, chroma_line_average_o})
    else $error("control one read back wrong");

  AST_UNMAPPED: assert property (psel_i && penable_i && paddr_i == 8'h00 |->
    pslverr_o && pready_o)
    else $error("unmapped access not refused");

  AST_VRATIO_LOW: assert property (s_write(`VAB_IDX_VRATIO_LOW) |=>
    vertical_ratio_o[7:0] == $past(pwdata_i[7:0]))
    else $error("vertical ratio low byte not written");

  AST_HRATIO_LOW: assert property (s_write(`VAB_IDX_HRATIO_LOW) |=>
    horizontal_ratio_o[7:0] == $past(pwdata_i[7:0]))
    else $error("horizontal ratio low byte not written");

  AST_BRIGHTNESS_OFFSET_WRITE: assert property (s_write(`VAB_IDX_BRIGHTNESS) |=>
    brightness_offset_o == $past(pwdata_i[7:0]))
    else $error("brightness not written");

  AST_CONTRAST_WRITE: assert property (s_write(`VAB_IDX_CONTRAST) |=>
    contrast_gain_o == $past(pwdata_i[7:0]))
    else $error("contrast not written");

  AST_SHARPEN_LEVEL_LEVEL: assert property (s_write(`VAB_IDX_SHARPEN) |=>
    sharpen_level_o == $past(pwdata_i[3:0]))
    else $error("sharpen level not written");

  // reads return the stored byte, unmapped reads return zero
  AST_READ_CONTRAST: assert property (s_read(`VAB_IDX_CONTRAST) |->
    prdata_o == {24'h00_0000, contrast_gain_o})
    else $error("contrast read back wrong");

  AST_READ_PIXEL: assert property (s_read(`VAB_IDX_PIXEL_LOW) |->
    prdata_o == {24'h00_0000, active_pixel_count_o[7:0]})
    else $error("pixel count low read back wrong");

  AST_READ_SCALE: assert property (s_read(`VAB_IDX_SCALE_HIGH) |->
    prdata_o == {24'h00_0000, vertical_ratio_o[11:8], horizontal_ratio_o[11:8]})
    else $error("scale high read back wrong");

  AST_READ_UNMAPPED: assert property (s_read(6'h13) |->
    prdata_o == 32'h0000_0000 && pslverr_o)
    else $error("unmapped read not zero");

  // a refused write must leave every field alone
  AST_REFUSED_WRITE: assert property (psel_i && penable_i && pwrite_i && pslverr_o |=>
    $stable({active_pixel_count_o, vertical_ratio_o, horizontal_ratio_o, brightness_offset_o,
    contrast_gain_o, ctrl, sharpen_level}))
    else $error("refused write changed a field");

  AST_ERR_ONLY_ACCESS: assert property (pslverr_o |->
    psel_i && penable_i)
    else $error("error raised outside an access");

  // pedestal lifts a plain sample by a fixed code
  AST_PEDESTAL_ADD: assert property (s_plain_sample ##0 (pedestal_select_o && luma_i < 8'h80) |=>
    luma_o == $past(luma_i) + `VAB_PEDESTAL_CODE)
    else $error("pedestal not added to luma");

  AST_CONTRAST_ZERO: assert property (luma_valid_i && contrast_gain_o == 8'h00 &&
    !pedestal_select_o && !brightness_offset_o[7] |=> luma_o == $past(brightness_offset_o))
    else $error("zero gain did not leave only the offset");

  // every accepted sample answers one cycle later, none otherwise
  AST_LUMA_VALID: assert property (luma_valid_o == $past(luma_valid_i))
    else $error("luma valid not one cycle behind");

  AST_LUMA_HOLD: assert property (!luma_valid_i |=> $stable(luma_o))
    else $error("luma output moved without a sample");

endmodule // vab_register_bank

// ### vab_register_bank_tb.sv
// self-checking bench of the video adjust register bank and its luma path
// assumes vab_consts.svh on the include path; apb master and stream share sys_clk_i
`timescale 1ns/100ps
`include "vab_consts.svh"

module vab_register_bank_tb;
  logic                     sys_clk_i, resetn_i, psel_i, penable_i, pwrite_i, luma_valid_i;
  logic [7:0]               paddr_i, luma_i, luma_o, brightness_offset_o, contrast_gain_o;
  logic [31:0]              pwdata_i, prdata_o, rd;
  logic                     pready_o, pslverr_o, wide_chroma_band_o, phase_switch_sensitivity_o;
  logic                     pedestal_select_o, comb_adaptive_o, luma_line_average_o, chroma_line_average_o;
  logic                     sharpen_centre_select_o, luma_valid_o, err;
  logic [9:0]               active_pixel_count_o;
  logic [11:0]              vertical_ratio_o, horizontal_ratio_o;
  logic [3:0]               sharpen_level_o;
  vab_pkg::vab_sharpen_level_mode_t sharpen_mode_o;
  int                       num_errors, num_checks, cycles;
  logic [5:0]               idx_tab [9];
  logic [7:0]               rst_tab [9];

  vab_register_bank vab_register_bank_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .active_pixel_count_o(active_pixel_count_o),
    .wide_chroma_band_o(wide_chroma_band_o), .phase_switch_sensitivity_o(phase_switch_sensitivity_o),
    .pedestal_select_o(pedestal_select_o), .comb_adaptive_o(comb_adaptive_o),
    .luma_line_average_o(luma_line_average_o), .chroma_line_average_o(chroma_line_average_o),
    .vertical_ratio_o(vertical_ratio_o), .horizontal_ratio_o(horizontal_ratio_o),
    .brightness_offset_o(brightness_offset_o), .contrast_gain_o(contrast_gain_o),
    .sharpen_centre_select_o(sharpen_centre_select_o), .sharpen_level_o(sharpen_level_o),
    .sharpen_mode_o(sharpen_mode_o), .luma_i(luma_i), .luma_valid_i(luma_valid_i), .luma_o(luma_o),
    .luma_valid_o(luma_valid_o));

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a hang guard well above the few hundred cycles needed
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic conclude();
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, {24'h0, d});
    @(negedge sys_clk_i);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, {idx, 2'b00}, 32'h0);
    chk(rd, {24'h0, exp});
    chk(32'(err), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_and_store();
    for (int i = 0; i < 9; i++)
      rd_chk(idx_tab[i], rst_tab[i]);
    chk(32'(active_pixel_count_o), 32'h2d0);
    chk(32'({vertical_ratio_o, horizontal_ratio_o}), 32'h100100);
    chk(32'({wide_chroma_band_o, phase_switch_sensitivity_o, pedestal_select_o}), 32'h4);
    chk(32'({sharpen_centre_select_o, contrast_gain_o}), 32'h060);
    // distinct patterns catch aliasing between slots
    for (int i = 0; i < 9; i++)
      wr_reg(idx_tab[i], 8'h5a ^ 8'(i * 17));
    for (int i = 0; i < 9; i++)
      rd_chk(idx_tab[i], 8'h5a ^ 8'(i * 17));
  endtask

  task automatic t_control_bits();
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(`VAB_IDX_CONTROL_ONE, 8'(1 << i));
      chk(32'({wide_chroma_band_o, 1'b0, phase_switch_sensitivity_o, pedestal_select_o,
               comb_adaptive_o, 1'b0, luma_line_average_o, chroma_line_average_o}),
               32'((1 << i) & 8'hbb));
      rd_chk(`VAB_IDX_CONTROL_ONE, 8'(1 << i));
    end
  endtask

  task automatic t_wide_fields();
    wr_reg(`VAB_IDX_CROP_HIGH, 8'hff);
    wr_reg(`VAB_IDX_PIXEL_LOW, 8'hff);
    chk(32'(active_pixel_count_o), 32'h3ff);
    wr_reg(`VAB_IDX_CROP_HIGH, 8'hfd);
    chk(32'(active_pixel_count_o), 32'h1ff);
    wr_reg(`VAB_IDX_VRATIO_LOW, 8'ha5);
    wr_reg(`VAB_IDX_HRATIO_LOW, 8'h3c);
    wr_reg(`VAB_IDX_SCALE_HIGH, 8'h9e);
    chk(32'(vertical_ratio_o), 32'h9a5);
    chk(32'(horizontal_ratio_o), 32'he3c);
  endtask

  task automatic t_sharpen();
    vab_pkg::vab_sharpen_level_mode_t m;
    for (int l = 0; l < 16; l++)
    begin
      m = (l == 0) ? vab_pkg::VAB_SHARPEN_LEVEL_OFF : (l < 8) ? vab_pkg::VAB_SHARPEN_LEVEL_ENHANCE : vab_pkg::VAB_SHARPEN_LEVEL_DENOISE;
      wr_reg(`VAB_IDX_SHARPEN, {l[0], 3'b010, 4'(l)});
      chk(32'({sharpen_centre_select_o, sharpen_level_o}), 32'({l[0], 4'(l)}));
      chk(32'(sharpen_mode_o), 32'(m));
    end
  endtask

  // settings, one sample, expected value worked from gain/64, signed offset and pedestal
  task automatic t_luma(input logic [7:0] c, input logic [7:0] b, input logic p, input logic [7:0] x);
    int v;
    wr_reg(`VAB_IDX_CONTRAST, c);
    wr_reg(`VAB_IDX_BRIGHTNESS, b);
    wr_reg(`VAB_IDX_CONTROL_ONE, {3'b000, p, 4'h0});
    chk(32'({contrast_gain_o, brightness_offset_o}), 32'({c, b}));
    v = ((int'(x) * int'(c)) >>> 6) + int'($signed(b)) + (p ? int'(`VAB_PEDESTAL_CODE) : 0);
    v = (v < 0) ? 0 : (v > 255) ? 255 : v;
    @(posedge sys_clk_i);
    luma_valid_i <= 1'b1;
    luma_i <= x;
    @(posedge sys_clk_i);
    luma_valid_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(32'({luma_valid_o, luma_o}), 32'h100 | 32'(v));
  endtask

  task automatic t_unmapped();
    wr_reg(`VAB_IDX_PIXEL_LOW, 8'h33);
    apb(1'b1, 8'h2d, 32'h0000_00cc);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'h4c, 32'h0000_00cc);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h4c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    rd_chk(`VAB_IDX_PIXEL_LOW, 8'h33);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    idx_tab = '{`VAB_IDX_CROP_HIGH, `VAB_IDX_PIXEL_LOW, `VAB_IDX_CONTROL_ONE, `VAB_IDX_VRATIO_LOW,
                `VAB_IDX_SCALE_HIGH, `VAB_IDX_HRATIO_LOW, `VAB_IDX_BRIGHTNESS, `VAB_IDX_CONTRAST, `VAB_IDX_SHARPEN};
    rst_tab = '{`VAB_RST_CROP_HIGH, `VAB_RST_PIXEL_LOW, `VAB_RST_CONTROL_ONE, `VAB_RST_VRATIO_LOW,
                `VAB_RST_SCALE_HIGH, `VAB_RST_HRATIO_LOW, `VAB_RST_BRIGHTNESS, `VAB_RST_CONTRAST, `VAB_RST_SHARPEN};
    {num_errors, num_checks, cycles} = '0;
    {psel_i, penable_i, pwrite_i, luma_valid_i, resetn_i} = '0;
    {paddr_i, luma_i, pwdata_i} = '0;
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_reset_and_store();
    t_control_bits();
    t_wide_fields();
    t_sharpen();
    t_luma(`VAB_CONTRAST_UNITY, 8'h00, 1'b0, 8'h7f);
    t_luma(`VAB_CONTRAST_UNITY, 8'h00, 1'b0, 8'hff);
    t_luma(8'h60, 8'h05, 1'b1, 8'h20);
    t_luma(8'h40, 8'h80, 1'b0, 8'h50);
    t_luma(8'hff, 8'h7f, 1'b0, 8'hff);
    t_luma(8'h00, 8'h10, 1'b0, 8'hc0);
    t_luma(`VAB_CONTRAST_UNITY, 8'h20, 1'b0, 8'h30);
    t_luma(`VAB_CONTRAST_UNITY, 8'h00, 1'b1, 8'h30);
    t_unmapped();
    conclude();
  end
endmodule // vab_register_bank_tb
